// ---- src/pcs_sequencer.sv ----
`timescale 1ns/1ps
module pcs_sequencer (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic cyc_en,
   input wire logic jump_req,
   input wire logic call_req,
   input wire logic ret_req,
   input wire logic irq_ack,
   input wire logic [pcs_pkg::TGT_W-1:0] jump_target,
   input wire logic [pcs_pkg::REG_ADDR_W-1:0] reg_addr,
   input wire logic [pcs_pkg::LO_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [pcs_pkg::LO_W-1:0] reg_rdata,
   output logic [pcs_pkg::PC_W-1:0] pc_out,
   output logic branch_taken
);

   logic rst_sync_n;

   logic [pcs_pkg::PC_W-1:0] pc_q;
   logic [pcs_pkg::PC_W-1:0] pc_d;
   logic [pcs_pkg::LO_W-1:0] latch_q;
   logic [pcs_pkg::LO_W-1:0] latch_d;
   logic [pcs_pkg::LO_W-1:0] rdata_q;
   logic [pcs_pkg::LO_W-1:0] rdata_d;
   logic taken_q;
   logic taken_d;

   pcs_pkg::pcs_op_t op;
   logic sel_low;
   logic sel_latch;
   logic wr_low;
   logic wr_latch;
   logic push;
   logic pop;
   logic [pcs_pkg::PC_W-1:0] push_data;
   logic [pcs_pkg::PC_W-1:0] pop_data;
   logic [pcs_pkg::PC_W-1:0] pc_inc;

   pcs_rst_sync u_rst_sync (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .rst_sync_n(rst_sync_n)
   );

   pcs_return_stack u_stack (
      .sys_clk(sys_clk),
      .rst_n(rst_sync_n),
      .push(push),
      .pop(pop),
      .push_data(push_data),
      .pop_data(pop_data)
   );

   // register decode
   always_comb begin
      sel_low = (reg_addr == pcs_pkg::REG_ADDR_LOW);
      sel_latch = (reg_addr == pcs_pkg::REG_ADDR_LATCH);
      wr_low = reg_wr && sel_low;
      wr_latch = reg_wr && sel_latch;
   end

   // operation select; interrupt beats every instruction action,
   // and a low-byte write replaces the plain step of that cycle
   always_comb begin
      op = pcs_pkg::PCS_OP_HOLD;
      if (cyc_en && irq_ack) begin
         op = pcs_pkg::PCS_OP_IRQ;
      end else if (cyc_en && call_req) begin
         op = pcs_pkg::PCS_OP_CALL;
      end else if (cyc_en && jump_req) begin
         op = pcs_pkg::PCS_OP_JUMP;
      end else if (cyc_en && ret_req) begin
         op = pcs_pkg::PCS_OP_RET;
      end else if (wr_low) begin
         op = pcs_pkg::PCS_OP_WRLO;
      end else if (cyc_en) begin
         op = pcs_pkg::PCS_OP_STEP;
      end
   end

   // stack control
   always_comb begin
      pc_inc = pc_q + pcs_pkg::PC_ONE;
      push = 1'b0;
      pop = 1'b0;
      push_data = pc_q;
      case (op)
         pcs_pkg::PCS_OP_IRQ: begin
            // interrupted instruction has not run yet: resume at it
            push = 1'b1;
            push_data = pc_q;
         end
         pcs_pkg::PCS_OP_CALL: begin
            push = 1'b1;
            push_data = pc_inc;
         end
         pcs_pkg::PCS_OP_RET: begin
            pop = 1'b1;
         end
         default: begin
            push = 1'b0;
            pop = 1'b0;
         end
      endcase
   end

   // program counter next value
   always_comb begin
      pc_d = pc_q;
      taken_d = 1'b0;
      case (op)
         pcs_pkg::PCS_OP_STEP: begin
            pc_d = pc_inc;
         end
         pcs_pkg::PCS_OP_IRQ: begin
            pc_d = pcs_pkg::IRQ_VECTOR;
            taken_d = 1'b1;
         end
         pcs_pkg::PCS_OP_CALL: begin
            pc_d = pcs_pkg::pcs_page_addr(latch_q, jump_target);
            taken_d = 1'b1;
         end
         pcs_pkg::PCS_OP_JUMP: begin
            pc_d = pcs_pkg::pcs_page_addr(latch_q, jump_target);
            taken_d = 1'b1;
         end
         pcs_pkg::PCS_OP_RET: begin
            // full 13 bits come back, page included
            pc_d = pop_data;
            taken_d = 1'b1;
         end
         pcs_pkg::PCS_OP_WRLO: begin
            // tables crossing a 256-word block need the latch set first
            pc_d = pcs_pkg::pcs_low_load(latch_q, reg_wdata);
            taken_d = 1'b1;
         end
         pcs_pkg::PCS_OP_HOLD: begin
            pc_d = pc_q;
         end
         default: begin
            pc_d = pc_q;
         end
      endcase
   end

   // latch changes only by software; stack actions never touch it
   always_comb begin
      latch_d = latch_q;
      if (wr_latch) begin
         latch_d = reg_wdata;
      end
   end

   // read port: upper counter byte and stack index are not mapped
   always_comb begin
      rdata_d = pcs_pkg::RDATA_ZERO;
      if (reg_rd && sel_low) begin
         rdata_d = pc_q[pcs_pkg::LO_W-1:0];
      end else if (reg_rd && sel_latch) begin
         rdata_d = latch_q;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         pc_q <= pcs_pkg::PC_RST;
         taken_q <= 1'b0;
      end else begin
         pc_q <= pc_d;
         taken_q <= taken_d;
      end
   end

   // reset only for a known simulation start; software treats it as unknown
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         latch_q <= pcs_pkg::LATCH_RST;
      end else begin
         latch_q <= latch_d;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         rdata_q <= pcs_pkg::RDATA_ZERO;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata = rdata_q;
   assign pc_out = pc_q;
   assign branch_taken = taken_q;

endmodule : pcs_sequencer

// ---- src/pcs_pkg.sv ----
package pcs_pkg;

   localparam int PC_W = 13;
   localparam int LO_W = 8;
   localparam int TGT_W = 11;
   localparam int STK_DEPTH = 8;
   localparam int STK_IDX_W = 3;
   localparam int REG_ADDR_W = 8;

   localparam logic [REG_ADDR_W-1:0] REG_ADDR_LOW = 8'h00;
   localparam logic [REG_ADDR_W-1:0] REG_ADDR_LATCH = 8'h01;

   localparam logic [LO_W-1:0] LATCH_RST = 8'h00;
   localparam logic [LO_W-1:0] RDATA_ZERO = 8'h00;
   localparam logic [PC_W-1:0] PC_RST = 13'h0000;
   localparam logic [PC_W-1:0] PC_ONE = 13'h0001;
   localparam logic [PC_W-1:0] IRQ_VECTOR = 13'h0004;
   localparam logic [STK_IDX_W-1:0] STK_IDX_RST = 3'h0;
   localparam logic [STK_IDX_W-1:0] STK_IDX_ONE = 3'h1;

   // latch field positions
   localparam int LATCH_PAGE_BIT = 3;
   localparam int LATCH_LOW_HI_MSB = 3;

   typedef enum logic [2:0] {
      PCS_OP_HOLD = 3'h0,
      PCS_OP_STEP = 3'h1,
      PCS_OP_IRQ = 3'h2,
      PCS_OP_CALL = 3'h3,
      PCS_OP_JUMP = 3'h4,
      PCS_OP_RET = 3'h5,
      PCS_OP_WRLO = 3'h6
   } pcs_op_t;

   // bit 12 stays zero: the upper latch bit is ignored on a 4K part
   function automatic logic [PC_W-1:0] pcs_page_addr(
      input logic [LO_W-1:0] latch,
      input logic [TGT_W-1:0] target
   );
      pcs_page_addr = {1'b0, latch[LATCH_PAGE_BIT], target};
   endfunction : pcs_page_addr

   function automatic logic [PC_W-1:0] pcs_low_load(
      input logic [LO_W-1:0] latch,
      input logic [LO_W-1:0] data
   );
      pcs_low_load = {1'b0, latch[LATCH_LOW_HI_MSB:0], data};
   endfunction : pcs_low_load

endpackage : pcs_pkg

// ---- src/pcs_rst_sync.sv ----
`timescale 1ns/1ps
module pcs_rst_sync (
   input wire logic sys_clk,
   input wire logic rst_n,
   output logic rst_sync_n
);

   logic meta_q;
   logic meta_d;
   logic sync_q;
   logic sync_d;

   always_comb begin
      meta_d = 1'b1;
      sync_d = meta_q;
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign rst_sync_n = sync_q;

endmodule : pcs_rst_sync

// ---- src/pcs_return_stack.sv ----
`timescale 1ns/1ps
module pcs_return_stack (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic push,
   input wire logic pop,
   input wire logic [pcs_pkg::PC_W-1:0] push_data,
   output logic [pcs_pkg::PC_W-1:0] pop_data
);

   // entries live only here, no address decode reaches them
   logic [pcs_pkg::PC_W-1:0] mem_q [pcs_pkg::STK_DEPTH];
   logic [pcs_pkg::STK_IDX_W-1:0] idx_q;
   logic [pcs_pkg::STK_IDX_W-1:0] idx_d;
   logic [pcs_pkg::STK_IDX_W-1:0] top_idx;

   // index wraps silently, nothing flags overflow or underflow
   always_comb begin
      top_idx = idx_q - pcs_pkg::STK_IDX_ONE;
      idx_d = idx_q;
      if (push) begin
         idx_d = idx_q + pcs_pkg::STK_IDX_ONE;
      end else if (pop) begin
         idx_d = top_idx;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         idx_q <= pcs_pkg::STK_IDX_RST;
      end else begin
         idx_q <= idx_d;
      end
   end

   // no reset on the array: contents are don't-care until pushed
   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem_q[idx_q] <= push_data;
      end
   end

   assign pop_data = mem_q[top_idx];

endmodule : pcs_return_stack

// ---- dv/pcs_chk.sv ----
`timescale 1ns/1ps
module pcs_chk (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic cyc_en,
   input wire logic jump_req,
   input wire logic call_req,
   input wire logic ret_req,
   input wire logic irq_ack,
   input wire logic [10:0] jump_target,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic [12:0] pc_out,
   input wire logic branch_taken
);
   logic [7:0] lat_q;
   logic [7:0] lat_d;
   logic seq;
   logic wlo;
   assign seq = cyc_en & (irq_ack | call_req | jump_req | ret_req);
   assign wlo = reg_wr & (reg_addr == 8'h00);
   // shadow of the latch, needed for page bits
   always_comb lat_d = (reg_wr && reg_addr == 8'h01) ? reg_wdata : lat_q;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) lat_q <= 8'h00;
      else lat_q <= lat_d;
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   property p_step;
      cyc_en && !seq && !wlo |=> pc_out == $past(pc_out) + 13'h0001 && !branch_taken;
   endproperty
   property p_hold; !cyc_en && !wlo |=> $stable(pc_out); endproperty
   property p_irq; cyc_en && irq_ack |=> pc_out == 13'h0004 && branch_taken; endproperty
   property p_br;
      cyc_en && !irq_ack && (call_req || jump_req)
         |=> pc_out == {1'b0, $past(lat_q[3]), $past(jump_target)};
   endproperty
   property p_wlo;
      wlo && !seq |=> pc_out == {1'b0, $past(lat_q[3:0]), $past(reg_wdata)} && branch_taken;
   endproperty
   property p_rlo; reg_rd && reg_addr == 8'h00 |=> reg_rdata == $past(pc_out[7:0]); endproperty
   property p_rlat; reg_rd && reg_addr == 8'h01 |=> reg_rdata == $past(lat_q); endproperty
   property p_rz; !(reg_rd && reg_addr < 8'h02) |=> reg_rdata == 8'h00; endproperty
   property p_seq_taken; seq |=> branch_taken; endproperty
   a_step: assert property (p_step) else $error("pc step wrong");
   a_hold: assert property (p_hold) else $error("pc moved while idle");
   a_irq: assert property (p_irq) else $error("irq vector wrong");
   a_br: assert property (p_br) else $error("branch target wrong");
   a_wlo: assert property (p_wlo) else $error("low write load wrong");
   a_rlo: assert property (p_rlo) else $error("low byte read wrong");
   a_rlat: assert property (p_rlat) else $error("latch read wrong");
   a_rz: assert property (p_rz) else $error("read data not zero");
   a_seq_taken: assert property (p_seq_taken) else $error("branch flag missing");
   c_irq: cover property (cyc_en && irq_ack);
   c_ret: cover property (cyc_en && ret_req);
   c_call: cover property (cyc_en && call_req);
   c_wlo: cover property (wlo);
endmodule : pcs_chk

// ---- dv/pcs_cpu_model.sv ----
`timescale 1ns/1ps
module pcs_cpu_model (
   input wire logic sys_clk,
   output logic cyc_en,
   output logic jump_req,
   output logic call_req,
   output logic ret_req,
   output logic irq_ack,
   output logic [10:0] jump_target
);
   initial {cyc_en, jump_req, call_req, ret_req, irq_ack, jump_target} = 16'h0000;
   // k: 0 idle 1 step 2 irq 3 call 4 jump 5 ret; idle ops give a slow decoder
   task automatic op(input int k, input logic [10:0] t);
      @(posedge sys_clk);
      cyc_en <= (k != 0);
      irq_ack <= (k == 2);
      call_req <= (k == 3);
      jump_req <= (k == 4);
      ret_req <= (k == 5);
      // target not held when unused, so a stale value cannot pass
      jump_target <= (k == 3 || k == 4) ? t : ~jump_target;
   endtask : op
endmodule : pcs_cpu_model

// ---- dv/testbench.sv ----
`timescale 1ns/1ps
module testbench;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic cyc_en, jump_req, call_req, ret_req, irq_ack, branch_taken;
   logic [10:0] jump_target;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic [12:0] pc_out;
   int miscompares = 0;
   int samples_checked = 0;
   always #10 sys_clk = ~sys_clk;
   pcs_cpu_model cpu (.sys_clk(sys_clk), .cyc_en(cyc_en), .jump_req(jump_req),
      .call_req(call_req), .ret_req(ret_req), .irq_ack(irq_ack), .jump_target(jump_target));
   pcs_sequencer dut (.sys_clk(sys_clk), .rst_n(rst_n), .cyc_en(cyc_en), .jump_req(jump_req),
      .call_req(call_req), .ret_req(ret_req), .irq_ack(irq_ack), .jump_target(jump_target),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .pc_out(pc_out), .branch_taken(branch_taken));
   task automatic end_sim;
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : end_sim
   task automatic chk_pc(input logic [12:0] got, input logic [12:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %0t pc got %h exp %h", $time, got, exp);
      end
   endtask : chk_pc
   task automatic chk_rdata(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %0t read data got %h exp %h", $time, got, exp);
      end
   endtask : chk_rdata
   task automatic chk_flag(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %0t branch flag got %b exp %b", $time, got, exp);
      end
   endtask : chk_flag
   task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_wr <= w;
      reg_rd <= r;
      reg_addr <= a;
      reg_wdata <= d;
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(1'b1, 1'b0, a, d);
      bus(1'b0, 1'b0, a, d);
      #1;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      bus(1'b0, 1'b1, a, 8'h00);
      bus(1'b0, 1'b0, a, 8'h00);
      #1 chk_rdata(reg_rdata, e);
   endtask : rd
   // branch flag pulses after irq, call, jump or return, and not after step or idle
   task automatic go(input int k, input logic [10:0] t, input logic [12:0] e);
      cpu.op(k, t);
      cpu.op(0, t);
      #1 chk_pc(pc_out, e);
      chk_flag(branch_taken, k > 1);
   endtask : go
   task automatic do_reset;
      rst_n <= 1'b0;
      repeat (16) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge sys_clk);
      #1 chk_pc(pc_out, 13'h0000);
      chk_flag(branch_taken, 1'b0);
      chk_rdata(reg_rdata, 8'h00);
   endtask : do_reset
   task automatic t_step;
      cpu.op(1, 11'h000);
      cpu.op(1, 11'h000);
      go(1, 11'h000, 13'h0003);
      go(0, 11'h000, 13'h0003);
      wr(8'h01, 8'h0f);
      wr(8'h00, 8'hff);
      go(1, 11'h000, 13'h1000);
   endtask : t_step
   task automatic t_wrlo;
      wr(8'h01, 8'h1a);
      wr(8'h00, 8'h55);
      chk_pc(pc_out, 13'h0a55);
      chk_flag(branch_taken, 1'b1);
      rd(8'h01, 8'h1a);
      rd(8'h00, 8'h55);
   endtask : t_wrlo
   task automatic t_jump;
      wr(8'h01, 8'h08);
      go(4, 11'h123, 13'h0923);
      wr(8'h01, 8'h00);
      go(4, 11'h7ff, 13'h07ff);
   endtask : t_jump
   task automatic t_callret;
      wr(8'h01, 8'h08);
      go(3, 11'h010, 13'h0810);
      wr(8'h01, 8'h00);
      go(5, 11'h000, 13'h0800);
      rd(8'h01, 8'h00);
      go(2, 11'h000, 13'h0004);
      go(5, 11'h000, 13'h0800);
   endtask : t_callret
   task automatic t_wrap;
      for (int i = 1; i < 10; i++) cpu.op(3, 11'(16 * i));
      for (int j = 0; j < 9; j++) begin
         cpu.op(5, 11'h000);
         #1 chk_pc(pc_out, (j == 0) ? 13'h0090 : 13'(16 * (9 - j) + 1));
      end
      go(0, 11'h000, 13'h0081);
   endtask : t_wrap
   task automatic t_unmapped;
      wr(8'h02, 8'haa);
      chk_flag(branch_taken, 1'b0);
      rd(8'h02, 8'h00);
      rd(8'hff, 8'h00);
      rd(8'h00, 8'h81);
   endtask : t_unmapped
   initial begin
      repeat (20000) @(posedge sys_clk);
      miscompares++;
      end_sim();
   end
   initial begin
      do_reset();
      t_step();
      t_wrlo();
      t_jump();
      t_callret();
      t_wrap();
      t_unmapped();
      do_reset();
      end_sim();
   end
endmodule : testbench
bind pcs_sequencer pcs_chk u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .cyc_en(cyc_en),
   .jump_req(jump_req), .call_req(call_req), .ret_req(ret_req), .irq_ack(irq_ack),
   .jump_target(jump_target), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pc_out(pc_out), .branch_taken(branch_taken));
